/* File: src/tca_pkg.sv */
// shared constants and types for the thermal conversion and alert block
package tca_pkg;
    // clock and conversion timing
    localparam int          CLK_HZ         = 200_000_000;
    localparam int          MS_PER_S       = 1000;
    localparam int          MS_CYCLES      = CLK_HZ / MS_PER_S;
    localparam int          MS_DIV_W       = 18;
    localparam int          CONV_PERIOD_MS = 100;
    localparam int          CONV_BUSY_MS   = 28;
    localparam logic [7:0]  PERIOD_DEF     = 8'(CONV_PERIOD_MS);
    localparam logic [7:0]  BUSY_LAST      = 8'(CONV_BUSY_MS - 1);
    localparam logic [7:0]  PERIOD_MIN     = 8'(CONV_BUSY_MS + 1);

    // field widths
    localparam int          TEMP_W         = 11;
    localparam int          LIMIT_W        = 9;
    localparam int          CFG_W          = 5;
    localparam int          CYCLE_W        = 8;

    // configuration bit positions
    localparam int          CFG_SHUTDOWN   = 0;
    localparam int          CFG_MODE       = 1;
    localparam int          CFG_POLARITY   = 2;
    localparam int          CFG_FQ_LSB     = 3;
    localparam int          CFG_FQ_MSB     = 4;

    // write selects
    localparam logic [1:0]  SEL_CFG        = 2'h0;
    localparam logic [1:0]  SEL_TOS        = 2'h1;
    localparam logic [1:0]  SEL_THYST      = 2'h2;
    localparam logic [1:0]  SEL_CYCLE      = 2'h3;

    // reset values: 80 and 75 degrees in half-degree steps
    localparam logic [4:0]  CFG_RST        = 5'h00;
    localparam logic [8:0]  TOS_RST        = 9'h0A0;
    localparam logic [8:0]  THYST_RST      = 9'h096;
    localparam logic [7:0]  CYCLE_RST      = 8'h00;
    localparam logic [10:0] TEMP_RST       = 11'h000;

    // target address: fixed upper nibble, pins fill the rest
    localparam logic [3:0]  ADDR_HI        = 4'h9;
    localparam logic [1:0]  BOOT_LATCH     = 2'h2;

    typedef enum logic {TCA_IDLE, TCA_BUSY} tca_state_t;

    typedef struct packed {
        tca_state_t                 st;
        logic [MS_DIV_W-1:0]        div;
        logic [7:0]                 ms;
        logic [TEMP_W-1:0]          temp;
        logic                       act;
        logic                       hyst_next;
        logic [2:0]                 faults;
        logic                       sd_prev;
        logic [CFG_W-1:0]           cfg;
        logic [LIMIT_W-1:0]         tos;
        logic [LIMIT_W-1:0]         thyst;
        logic [CYCLE_W-1:0]         cycle;
        logic                       oe;
        logic [6:0]                 addr;
        logic [1:0]                 boot;
        logic                       addr_ok;
    } tca_regs_t;

    // consecutive faults needed for each fault-queue code
    function automatic logic [2:0] tca_fault_limit(input logic [1:0] code);
        logic [2:0] lim;
        lim = 3'h1;
        unique case (code)
            2'h0: lim = 3'h1;
            2'h1: lim = 3'h2;
            2'h2: lim = 3'h4;
            2'h3: lim = 3'h6;
        endcase
        return lim;
    endfunction : tca_fault_limit
endpackage : tca_pkg

/* File: src/tca_sync.sv */
// two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module tca_sync #(
    parameter int W = 1
) (
    input  wire logic         clock_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_r <= '0;
            q_out  <= '0;
        end
        else
        begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule : tca_sync
`default_nettype wire

/* File: src/tca_core.sv */
// conversion scheduler, result store and over-temperature alert
// Behaviour
// - result kept as 11-bit signed, 0.125 C steps
// - result readable any time, conversion undisturbed
// - normal mode converts once per conversion period
// - 28 ms busy, then idle rest of period
// - shutdown stops conversions, keeps result, writes work
// - shutdown bit selects shutdown or normal
// - conversion starts at reset and on wake
// - each normal-mode conversion updates alert comparison
// - 9-bit limits, compare top nine result bits
// - alert mode bit picks comparator or interrupt
// - comparator: set above threshold, clear below hysteresis
// - comparator: reads and shutdown leave alert alone
// - interrupt: trip above threshold, held until read
// - interrupt: alternate threshold and hysteresis trips
// - interrupt: entering shutdown clears the alert
// - alert changes after programmed consecutive faults
// - polarity bit selects alert active level
// - reset: normal, comparator, 80/75 C, low, 1
// - result reads zero until first conversion ends
// - alert pin open-drain, never driven high
// - three address pins form low target address bits
// - conversion-cycle register programs period, zero is default
`timescale 1ns/1ps
`default_nettype none
module tca_core
    import tca_pkg::*;
#(
    parameter int MS_CYC = tca_pkg::MS_CYCLES
) (
    // clock and reset
    input  wire logic                         clock_in,
    input  wire logic                         rst_n_in,
    // register access from the bus logic, same clock
    input  wire logic                         wr_en_in,
    input  wire logic [1:0]                   wr_sel_in,
    input  wire logic [tca_pkg::LIMIT_W-1:0]  wr_data_in,
    input  wire logic                         reg_read_in,
    // converter sample and address pins, asynchronous
    input  wire logic [tca_pkg::TEMP_W-1:0]   adc_sample_in,
    input  wire logic                         addr_select_0_in,
    input  wire logic                         addr_select_1_in,
    input  wire logic                         addr_select_2_in,
    // register contents
    output var  logic [tca_pkg::TEMP_W-1:0]   temp_result_out,
    output var  logic [tca_pkg::CFG_W-1:0]    config_out,
    output var  logic [tca_pkg::LIMIT_W-1:0]  tos_out,
    output var  logic [tca_pkg::LIMIT_W-1:0]  thyst_out,
    output var  logic [tca_pkg::CYCLE_W-1:0]  conv_cycle_out,
    // status
    output var  logic                         conv_busy_out,
    output var  logic [6:0]                   bus_address_out,
    output var  logic                         bus_address_valid_out,
    // open-drain alert pin
    output var  logic                         thermal_alert_out,
    output var  logic                         thermal_alert_oe_out
);
    import tca_pkg::*;

    tca_regs_t                r_r;
    tca_regs_t                r_nxt;
    logic [TEMP_W-1:0]        sample_s;
    logic [2:0]               addr_s;
    logic                     tick;
    logic                     fin;
    logic                     start;
    logic                     wake;
    logic                     sd_enter;
    logic [7:0]               period;
    logic signed [LIMIT_W-1:0] t9;
    logic                     hot;
    logic                     cold;
    logic                     cond;
    logic [2:0]               fcount;

    // converter word is held steady by the converter while it is captured
    tca_sync #(
        .W (TEMP_W + 3)
    ) u_sync (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .d_in     ({adc_sample_in, addr_select_2_in, addr_select_1_in, addr_select_0_in}),
        .q_out    ({sample_s, addr_s})
    );

    always_comb
    begin
        r_nxt = r_r;
        tick  = (r_r.div == MS_DIV_W'(MS_CYC - 1));
        r_nxt.div = tick ? '0 : r_r.div + 1'b1;
        if (tick)
        begin
            r_nxt.ms = r_r.ms + 8'h01;
        end

        if (r_r.cycle == CYCLE_RST)
        begin
            period = PERIOD_DEF;
        end
        else if (r_r.cycle < PERIOD_MIN)
        begin
            period = PERIOD_MIN;
        end
        else
        begin
            period = r_r.cycle;
        end

        wake     = r_r.sd_prev && !r_r.cfg[CFG_SHUTDOWN];
        sd_enter = !r_r.sd_prev && r_r.cfg[CFG_SHUTDOWN];
        r_nxt.sd_prev = r_r.cfg[CFG_SHUTDOWN];

        fin = (r_r.st == TCA_BUSY) && tick && (r_r.ms == BUSY_LAST) && !r_r.cfg[CFG_SHUTDOWN];
        start = !r_r.cfg[CFG_SHUTDOWN]
              && (((r_r.st == TCA_IDLE) && tick && (r_r.ms == period - 8'h01)) || wake);

        unique case (r_r.st)
            TCA_IDLE:
            begin
                if (start)
                begin
                    r_nxt.st  = TCA_BUSY;
                    r_nxt.div = '0;
                    r_nxt.ms  = '0;
                end
            end
            TCA_BUSY:
            begin
                if (fin)
                begin
                    r_nxt.st = TCA_IDLE;
                end
            end
        endcase
        // shutdown aborts a conversion, result untouched
        if (r_r.cfg[CFG_SHUTDOWN])
        begin
            r_nxt.st = TCA_IDLE;
        end

        // a read clears a pending interrupt
        if (reg_read_in && r_r.cfg[CFG_MODE])
        begin
            r_nxt.act = 1'b0;
        end
        if (sd_enter && r_r.cfg[CFG_MODE])
        begin
            r_nxt.act = 1'b0;
        end

        t9   = signed'(sample_s[TEMP_W-1:TEMP_W-LIMIT_W]);
        hot  = t9 > signed'(r_r.tos);
        cold = t9 < signed'(r_r.thyst);
        if (r_r.cfg[CFG_MODE])
        begin
            cond = !r_nxt.act && (r_r.hyst_next ? cold : hot);
        end
        else
        begin
            cond = r_r.act ? cold : hot;
        end
        fcount = r_r.faults + 3'h1;

        if (fin)
        begin
            r_nxt.temp = sample_s;
            if (cond)
            begin
                if (fcount >= tca_fault_limit(r_r.cfg[CFG_FQ_MSB:CFG_FQ_LSB]))
                begin
                    r_nxt.faults = '0;
                    if (r_r.cfg[CFG_MODE])
                    begin
                        r_nxt.act       = 1'b1;
                        r_nxt.hyst_next = !r_r.hyst_next;
                    end
                    else
                    begin
                        r_nxt.act = !r_r.act;
                    end
                end
                else
                begin
                    r_nxt.faults = fcount;
                end
            end
            else
            begin
                r_nxt.faults = '0;
            end
        end

        if (wr_en_in)
        begin
            unique case (wr_sel_in)
                SEL_CFG:   r_nxt.cfg   = wr_data_in[CFG_W-1:0];
                SEL_TOS:   r_nxt.tos   = wr_data_in;
                SEL_THYST: r_nxt.thyst = wr_data_in;
                SEL_CYCLE: r_nxt.cycle = wr_data_in[CYCLE_W-1:0];
            endcase
        end

        // pull low only, polarity chooses when
        r_nxt.oe = r_nxt.act ^ r_nxt.cfg[CFG_POLARITY];

        // latch pins once the synchroniser has settled
        if (!r_r.addr_ok)
        begin
            r_nxt.boot = r_r.boot + 2'h1;
            if (r_r.boot == BOOT_LATCH)
            begin
                r_nxt.addr    = {ADDR_HI, addr_s};
                r_nxt.addr_ok = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            r_r <= '{st: TCA_BUSY, div: '0, ms: '0, temp: TEMP_RST, act: 1'b0,
                     hyst_next: 1'b0, faults: '0, sd_prev: 1'b0, cfg: CFG_RST,
                     tos: TOS_RST, thyst: THYST_RST, cycle: CYCLE_RST, oe: 1'b0,
                     addr: '0, boot: '0, addr_ok: 1'b0};
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    // registers are plain flop outputs; a read changes only the alert enable, and only in interrupt mode
    assign temp_result_out       = r_r.temp;
    assign config_out            = r_r.cfg;
    assign tos_out               = r_r.tos;
    assign thyst_out             = r_r.thyst;
    assign conv_cycle_out        = r_r.cycle;
    assign conv_busy_out         = (r_r.st == TCA_BUSY);
    assign bus_address_out       = r_r.addr;
    assign bus_address_valid_out = r_r.addr_ok;
    assign thermal_alert_oe_out  = r_r.oe;
    // open-drain: the data side of the pin is a constant low
    assign thermal_alert_out     = 1'b0;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_sd_on;
        $rose(r_r.cfg[CFG_SHUTDOWN]);
    endsequence
    sequence s_wake;
        $fell(r_r.sd_prev) ##0 !r_r.cfg[CFG_SHUTDOWN];
    endsequence

    a_result_held: assert property (!fin |=> $stable(r_r.temp))
        else $error("result changed outside conversion end");
    // a normal end leaves the millisecond count equal to the busy time (28), divider wrapped
    a_busy_time: assert property ($fell(conv_busy_out) && !r_r.cfg[CFG_SHUTDOWN] &&
        !$past(r_r.cfg[CFG_SHUTDOWN]) |-> r_r.ms == BUSY_LAST + 8'h01 && r_r.div == '0)
        else $error("conversion ended at wrong time");
    a_period_start: assert property ($rose(conv_busy_out) |-> $past(wake) ||
        ($past(r_r.ms) == period - 8'h01))
        else $error("conversion started off period");
    a_sd_stops: assert property (s_sd_on |=> !conv_busy_out [*3])
        else $error("conversion ran in shutdown");
    a_wake_starts: assert property (s_wake |=> conv_busy_out)
        else $error("no conversion on wake");
    a_pin_low: assert property (thermal_alert_out == 1'b0)
        else $error("alert pin driven high");
    a_pol_level: assert property (thermal_alert_oe_out == (r_r.act ^ r_r.cfg[CFG_POLARITY]))
        else $error("alert enable mismatches polarity");
    a_read_clears: assert property (reg_read_in && r_r.cfg[CFG_MODE] && !fin |=> !r_r.act)
        else $error("read did not clear interrupt");
    a_cmp_steady: assert property (!fin && !r_r.cfg[CFG_MODE] && !wr_en_in |=> $stable(r_r.act))
        else $error("comparator alert changed without conversion");
    a_int_sd_clr: assert property (s_sd_on ##0 r_r.cfg[CFG_MODE] && !wr_en_in |=> !r_r.act)
        else $error("shutdown did not clear interrupt alert");
    a_addr_form: assert property (bus_address_valid_out |-> bus_address_out[6:3] == ADDR_HI)
        else $error("target address malformed");

    // the address is latched once and then never moves
    a_addr_latched: assert property (bus_address_valid_out |=> bus_address_valid_out &&
        $stable(bus_address_out))
        else $error("target address moved after latch");

    a_temp_capture: assert property (fin |=> temp_result_out == $past(sample_s))
        else $error("result not captured at conversion end");

    a_sd_result: assert property (r_r.cfg[CFG_SHUTDOWN] |=> $stable(r_r.temp))
        else $error("result changed in shutdown");

    a_tos_write: assert property (wr_en_in && (wr_sel_in == SEL_TOS) |=> tos_out == $past(wr_data_in))
        else $error("threshold write lost");

    // fault counting between trips
    a_fault_clear: assert property (fin && !cond |=> r_r.faults == 3'h0)
        else $error("fault count not restarted");
    a_fault_step: assert property (fin && cond &&
        (fcount < tca_fault_limit(r_r.cfg[CFG_FQ_MSB:CFG_FQ_LSB])) |=> r_r.faults == $past(fcount))
        else $error("fault count did not advance");

    // with a single-fault queue the comparator follows each conversion
    a_cmp_trip: assert property (fin && !r_r.cfg[CFG_MODE] && !r_r.act && hot &&
        (r_r.cfg[CFG_FQ_MSB:CFG_FQ_LSB] == 2'h0) |=> r_r.act)
        else $error("comparator did not trip above threshold");
    a_cmp_release: assert property (fin && !r_r.cfg[CFG_MODE] && r_r.act && cold &&
        (r_r.cfg[CFG_FQ_MSB:CFG_FQ_LSB] == 2'h0) |=> !r_r.act)
        else $error("comparator did not release below hysteresis");

    // an interrupt stays up until a read or shutdown
    a_int_hold: assert property (r_r.cfg[CFG_MODE] && r_r.act && !reg_read_in &&
        !r_r.cfg[CFG_SHUTDOWN] |=> r_r.act)
        else $error("interrupt alert dropped without read");
endmodule : tca_core
`default_nettype wire

/* File: verif/tca_far_end.sv */
// far side model: sensor word on the link clock and the pulled-up alert line
`timescale 1ns/1ps
`default_nettype none
module tca_far_end
    import tca_pkg::*;
(
    // link clock and wanted sample
    input  wire logic                       link_clk_in,
    input  wire logic [tca_pkg::TEMP_W-1:0] temp_req_in,
    // alert pin from the block
    input  wire logic                       alert_data_in,
    input  wire logic                       alert_oe_in,
    // converter word and resolved line
    output var  logic [tca_pkg::TEMP_W-1:0] sample_out,
    output var  logic                       alert_line_out
);
    initial sample_out = '0;
    // the word moves only on link edges, unrelated in phase to the core clock
    always @(posedge link_clk_in)
        sample_out <= temp_req_in;
    // released line floats up through the pull-up
    assign alert_line_out = alert_oe_in ? alert_data_in : 1'b1;
endmodule : tca_far_end
`default_nettype wire

/* File: verif/test_thermal_conversion_and_alert.sv */
// self-checking bench for the thermal conversion and alert core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD %0t line %0d", $time, `__LINE__); end end
module test_thermal_conversion_and_alert;
    import tca_pkg::*;
    logic              clock_in = 1'b0;
    logic              rst_n_in = 1'b0;
    logic              link_clk = 1'b0;
    logic              wr_en = 1'b0;
    logic              rd = 1'b0;
    logic [1:0]        wr_sel = 2'h0;
    logic [8:0]        wr_data = 9'h000;
    logic [2:0]        addr = 3'h0;
    logic [10:0]       temp_req = 11'h000;
    logic [10:0]       sample, temp_out;
    logic [4:0]        cfg_out;
    logic [8:0]        tos_out, thy_out;
    logic [7:0]        cyc_out;
    logic [6:0]        bus_addr;
    logic              busy, addr_ok, al_data, al_oe, al_line, act, hn, pol, mode;
    logic [1:0]        code;
    logic signed [8:0] tos, thy;
    logic [31:0]       lfsr = 32'h6F48;
    int                error_cnt = 0;
    int                check_count = 0;
    int                cnt, n;

    always #2.5 clock_in = ~clock_in;
    initial
    begin
        #1.3;
        forever #40 link_clk = ~link_clk;
    end

    tca_core #(.MS_CYC(10)) dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .wr_en_in(wr_en), .wr_sel_in(wr_sel),
        .wr_data_in(wr_data), .reg_read_in(rd), .adc_sample_in(sample), .addr_select_0_in(addr[0]),
        .addr_select_1_in(addr[1]), .addr_select_2_in(addr[2]), .temp_result_out(temp_out), .config_out(cfg_out),
        .tos_out(tos_out), .thyst_out(thy_out), .conv_cycle_out(cyc_out), .conv_busy_out(busy),
        .bus_address_out(bus_addr), .bus_address_valid_out(addr_ok), .thermal_alert_out(al_data),
        .thermal_alert_oe_out(al_oe));
    tca_far_end far (.link_clk_in(link_clk), .temp_req_in(temp_req), .alert_data_in(al_data),
        .alert_oe_in(al_oe), .sample_out(sample), .alert_line_out(al_line));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic int nfault(input logic [1:0] c);
        return (c == 2'h0) ? 1 : (c == 2'h1) ? 2 : (c == 2'h2) ? 4 : 6;
    endfunction : nfault
    // equal to a limit is no fault, so it restarts the count
    function automatic logic [10:0] pick(input int i, input int nf, input logic hot, input logic [3:0] r);
        logic signed [8:0] t;
        t = hot ? tos + 9'sd1 + r[3:2] : thy - 9'sd1 - r[3:2];
        if (i == nf - 1)
            t = hot ? tos : thy;
        return {t, r[1:0]};
    endfunction : pick
    function automatic logic [8:0] cfgv(input logic sd);
        return {4'h0, code, pol, mode, sd};
    endfunction : cfgv

    task automatic wr(input logic [1:0] s, input logic [8:0] d);
        @(negedge clock_in);
        wr_en = 1'b1;
        wr_sel = s;
        wr_data = d;
        @(negedge clock_in);
        wr_en = 1'b0;
    endtask : wr
    task automatic rd_pulse();
        @(negedge clock_in);
        rd = 1'b1;
        @(negedge clock_in);
        rd = 1'b0;
    endtask : rd_pulse
    task automatic wait_busy(input logic lvl);
        n = 0;
        while (busy !== lvl && n < 2000)
        begin
            @(negedge clock_in);
            n++;
        end
        `CHK(n < 2000, 1'b1)
    endtask : wait_busy
    task automatic check_alert();
        `CHK(al_oe, act ^ pol)
        `CHK(al_line, ~(act ^ pol))
        `CHK(al_data, 1'b0)
    endtask : check_alert
    task automatic convert(input logic [10:0] t, input logic clr);
        logic f;
        temp_req = t;
        wait_busy(1'b1);
        rd_pulse();
        wait_busy(1'b0);
        `CHK(temp_out, t)
        // top nine bits, strict signed compare
        f = (mode ? hn : act) ? ($signed(t[10:2]) < thy) : ($signed(t[10:2]) > tos);
        cnt = f ? cnt + 1 : 0;
        if (cnt == nfault(code))
        begin
            cnt = 0;
            act = mode | ~act;
            hn = hn ^ mode;
        end
        check_alert();
        if (clr)
        begin
            rd_pulse();
            act = act & ~mode;
            check_alert();
        end
    endtask : convert
    task automatic shut_test();
        logic [10:0] kept;
        kept = temp_out;
        wait_busy(1'b1);
        repeat (20) @(negedge clock_in);
        check_alert();
        wr(SEL_CFG, cfgv(1'b1));
        @(negedge clock_in);
        act = act & ~mode;
        `CHK(busy, 1'b0)
        check_alert();
        temp_req = ~kept;
        repeat (600) @(negedge clock_in);
        `CHK({busy, temp_out}, {1'b0, kept})
        wr(SEL_CFG, cfgv(1'b0));
        repeat (3) @(negedge clock_in);
        `CHK(busy, 1'b1)
        convert(~kept, 1'b1);
        $display("shutdown test done");
    endtask : shut_test
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    // the run needs about 39k cycles; this leaves a wide margin
    initial
    begin
        #400_000;
        error_cnt++;
        test_done();
    end

    initial
    begin
        for (int m = 0; m < 2; m++)
        begin
            lfsr = lfsr_next(lfsr);
            temp_req = 11'(lfsr[8:0]);
            addr = lfsr[12:10];
            rst_n_in = 1'b0;
            repeat (2) @(negedge clock_in);
            rst_n_in = 1'b1;
            {act, hn, mode, pol, code} = 5'h00;
            cnt = 0;
            tos = 9'sh0A0;
            thy = 9'sh096;
            `CHK({cfg_out, tos_out, thy_out, cyc_out, temp_out}, {5'h00, 9'h0A0, 9'h096, 8'h00, 11'h000})
            `CHK({busy, al_oe}, 2'b10)
            wait_busy(1'b0);
            `CHK(n > 276 && n < 282, 1'b1)
            `CHK(temp_out, temp_req)
            `CHK({addr_ok, bus_addr}, {1'b1, 4'h9, addr})
            check_alert();
            wait_busy(1'b1);
            `CHK(n > 716 && n < 722, 1'b1)
            lfsr = lfsr_next(lfsr);
            mode = m[0];
            pol = lfsr[5];
            tos = 9'(lfsr[31:24] % 96) + 9'sd20;
            thy = tos - 9'sd2 - lfsr[2:0];
            wr(SEL_TOS, tos);
            wr(SEL_THYST, thy);
            wr(SEL_CYCLE, 9'h01D);
            for (int c = 0; c < 4; c++)
            begin
                code = c[1:0];
                wr(SEL_CFG, cfgv(1'b0));
                `CHK({cfg_out, tos_out, thy_out, cyc_out}, {code, pol, mode, 1'b0, tos, thy, 8'h1D})
                for (int h = 1; h >= 0; h--)
                begin
                    for (int i = 0; i <= 2 * nfault(code); i++)
                    begin
                        lfsr = lfsr_next(lfsr);
                        convert(pick(i, nfault(code), h[0], lfsr[3:0]),
                                !(h == 1 && i == 2 * nfault(code) && c == 3));
                    end
                    if (h == 1 && c == 3)
                        shut_test();
                end
                $display("mode %0d fault code %0d done", m, c);
            end
        end
        test_done();
    end
endmodule : test_thermal_conversion_and_alert
`default_nettype wire
